// file: rf_cfg_host_ctrl.sv
// controller end: axi4-lite registers driving the rf register link
`timescale 1ns/1ps
module rf_cfg_host_ctrl #(
  parameter int ADDR_W = 4
) (
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  rf_cfg_link_if.host            lk,
  input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic              i_s_axi_awvalid,
  output logic                   o_s_axi_awready,
  input  wire logic [31:0]       i_s_axi_wdata,
  input  wire logic [3:0]        i_s_axi_wstrb,
  input  wire logic              i_s_axi_wvalid,
  output logic                   o_s_axi_wready,
  output logic [1:0]             o_s_axi_bresp,
  output logic                   o_s_axi_bvalid,
  input  wire logic              i_s_axi_bready,
  input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic              i_s_axi_arvalid,
  output logic                   o_s_axi_arready,
  output logic [31:0]            o_s_axi_rdata,
  output logic [1:0]             o_s_axi_rresp,
  output logic                   o_s_axi_rvalid,
  input  wire logic              i_s_axi_rready,
  output logic                   o_init_done
);
  rf_cfg_pkg::host_state_t state_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [15:0]       cmd_q;
  logic              cmd_go_q;
  logic [2:0]        init_idx_q;
  logic [7:0]        last_rd_q;
  logic              req_q;
  logic              we_q;
  logic [5:0]        addr_q;
  logic [7:0]        wdata_q;
  logic              do_write;
  logic              cmd_hit;

  assign lk.req   = req_q;
  assign lk.we    = we_q;
  assign lk.addr  = addr_q;
  assign lk.wdata = wdata_q;

  assign do_write = aw_have_q && w_have_q && !o_s_axi_bvalid;
  assign cmd_hit  = awaddr_q == rf_cfg_pkg::AXI_OFF_CMD;

  // write channels taken in either order, answered once both are in
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      aw_have_q       <= 1'b0;
      w_have_q        <= 1'b0;
      awaddr_q        <= '0;
      cmd_q           <= '0;
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready  <= 1'b1;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= rf_cfg_pkg::RESP_OKAY;
      cmd_go_q        <= 1'b0;
    end
    else
    begin
      cmd_go_q <= 1'b0;
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
        aw_have_q       <= 1'b1;
        awaddr_q        <= i_s_axi_awaddr;
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
        w_have_q       <= 1'b1;
        cmd_q          <= i_s_axi_wdata[15:0];
        o_s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_have_q      <= 1'b0;
        w_have_q       <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        // a command while busy, or an unmapped write, is refused
        if (cmd_hit && state_q == rf_cfg_pkg::S_IDLE && !cmd_go_q)
        begin
          cmd_go_q      <= 1'b1;
          o_s_axi_bresp <= rf_cfg_pkg::RESP_OKAY;
        end
        else
          o_s_axi_bresp <= rf_cfg_pkg::RESP_SLVERR;
      end
      if (o_s_axi_bvalid && i_s_axi_bready)
      begin
        o_s_axi_bvalid  <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= '0;
      o_s_axi_rresp   <= rf_cfg_pkg::RESP_OKAY;
    end
    else if (i_s_axi_arvalid && o_s_axi_arready)
    begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b1;
      o_s_axi_rresp   <= rf_cfg_pkg::RESP_OKAY;
      if (i_s_axi_araddr == rf_cfg_pkg::AXI_OFF_STATUS)
        o_s_axi_rdata <= {22'h000000, o_init_done,
                          state_q != rf_cfg_pkg::S_IDLE, last_rd_q};
      else if (i_s_axi_araddr == rf_cfg_pkg::AXI_OFF_CMD)
        o_s_axi_rdata <= {16'h0000, cmd_q};
      else
      begin
        o_s_axi_rdata <= '0;
        o_s_axi_rresp <= rf_cfg_pkg::RESP_SLVERR;
      end
    end
    else if (o_s_axi_rvalid && i_s_axi_rready)
    begin
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_arready <= 1'b1;
    end
  end

  // start-up writes first, then software commands one at a time
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_q     <= rf_cfg_pkg::S_INIT;
      init_idx_q  <= '0;
      req_q       <= 1'b0;
      we_q        <= 1'b0;
      addr_q      <= '0;
      wdata_q     <= '0;
      last_rd_q   <= '0;
      o_init_done <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        rf_cfg_pkg::S_INIT:
          if (!req_q)
          begin
            // analog bit 6 goes first so the gain write lands
            req_q   <= 1'b1;
            we_q    <= 1'b1;
            addr_q  <= rf_cfg_pkg::INIT_ADDR[init_idx_q];
            wdata_q <= rf_cfg_pkg::INIT_DATA[init_idx_q];
          end
          else if (lk.ack)
          begin
            req_q <= 1'b0;
            if (init_idx_q == 3'(rf_cfg_pkg::INIT_LEN - 1))
            begin
              state_q     <= rf_cfg_pkg::S_IDLE;
              o_init_done <= 1'b1;
            end
            else
              init_idx_q <= init_idx_q + 3'h1;
          end
        rf_cfg_pkg::S_IDLE:
          if (cmd_go_q)
          begin
            req_q   <= 1'b1;
            we_q    <= cmd_q[rf_cfg_pkg::CMD_BIT_WRITE];
            addr_q  <= cmd_q[13:8];
            wdata_q <= cmd_q[7:0];
            state_q <= rf_cfg_pkg::S_XFER;
          end
        rf_cfg_pkg::S_XFER:
          if (lk.ack)
          begin
            req_q <= 1'b0;
            if (!we_q)
              last_rd_q <= lk.rdata;
            state_q <= rf_cfg_pkg::S_IDLE;
          end
        default: state_q <= rf_cfg_pkg::S_IDLE;
      endcase
    end
  end
endmodule : rf_cfg_host_ctrl

// file: rf_cfg_pkg.sv
// shared constants for the rf configuration register set and its controller
package rf_cfg_pkg;
  // device register offsets (byte addresses on the link)
  localparam logic [5:0] OFF_CTL_ANALOG   = 6'h20;
  localparam logic [5:0] OFF_CHANNEL      = 6'h21;
  localparam logic [5:0] OFF_STRENGTH     = 6'h22;
  localparam logic [5:0] OFF_TX_POWER     = 6'h23;
  localparam logic [5:0] OFF_CRYSTAL      = 6'h24;
  localparam logic [5:0] OFF_VCO_SLOPE    = 6'h26;
  localparam logic [5:0] OFF_GAIN_LOCK    = 6'h2e;
  localparam logic [5:0] OFF_CARRIER      = 6'h2f;
  localparam logic [5:0] OFF_CLK_OVERRIDE = 6'h32;
  localparam logic [5:0] OFF_CLK_ENABLE   = 6'h33;
  localparam logic [5:0] OFF_LOCK_DELAY   = 6'h38;
  localparam logic [5:0] OFF_ID_BYTE0     = 6'h3c;
  localparam logic [5:0] OFF_ID_BYTE3     = 6'h3f;

  // field positions
  localparam int BIT_USE_COUNTERS = 7;
  localparam int BIT_GAIN_ENABLE  = 6;
  localparam int BIT_ID_READ      = 5;
  localparam int BIT_CLKOUT_OFF   = 6;
  localparam int BIT_GAIN_HOLD    = 7;
  localparam int BIT_CARRIER_OVR  = 7;
  localparam int BIT_STRENGTH_OK  = 5;

  // reset values
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_LOCK_DELAY = 8'h64;

  // channel 1 sits at 2402 MHz, 1 MHz per step
  localparam logic [11:0] CHAN_BASE_MHZ = 12'h961;

  // lock delay unit
  localparam int CLK_MHZ      = 100;
  localparam int LOCK_UNIT_NS = 2000;
  localparam int LOCK_UNIT_CYC = (LOCK_UNIT_NS * CLK_MHZ + 999) / 1000;

  // host start-up sequence
  localparam int INIT_LEN = 7;
  localparam logic [5:0] INIT_ADDR [INIT_LEN] = '{
    OFF_CTL_ANALOG, OFF_GAIN_LOCK, OFF_VCO_SLOPE, OFF_CLK_OVERRIDE,
    OFF_CLK_ENABLE, OFF_TX_POWER, OFF_CRYSTAL};
  localparam logic [7:0] INIT_DATA [INIT_LEN] = '{
    8'h40, 8'h80, 8'hc0, 8'h41, 8'h41, 8'h07, 8'h40};

  // controller registers on the software bus
  localparam logic [3:0] AXI_OFF_CMD    = 4'h0;
  localparam logic [3:0] AXI_OFF_STATUS = 4'h4;
  localparam int CMD_BIT_WRITE = 15;
  localparam int STAT_BIT_BUSY = 8;
  localparam int STAT_BIT_INIT = 9;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {S_INIT, S_IDLE, S_XFER} host_state_t;
endpackage : rf_cfg_pkg

// file: rf_cfg_link_if.sv
// register link between the controller and the rf configuration registers
`timescale 1ns/1ps
interface rf_cfg_link_if;
  logic       req;
  logic       we;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;

  modport host (output req, output we, output addr, output wdata,
                input ack, input rdata);
  modport device (input req, input we, input addr, input wdata,
                  output ack, output rdata);
endinterface : rf_cfg_link_if

// file: synth_settle_timer.sv
// synthesizer settling wait counted in lock-delay units
`timescale 1ns/1ps
module synth_settle_timer #(
  parameter int UNIT_CYC = rf_cfg_pkg::LOCK_UNIT_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_start,
  input  wire logic [7:0] i_units,
  output logic            o_done
);
  logic [7:0]  units_q;
  logic [15:0] cyc_q;
  logic        run_q;

  // restart drops done; a zero count finishes at once
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      units_q <= '0;
      cyc_q   <= '0;
      run_q   <= 1'b0;
      o_done  <= 1'b0;
    end
    else if (i_start)
    begin
      units_q <= i_units;
      cyc_q   <= '0;
      run_q   <= (i_units != 8'h00);
      o_done  <= (i_units == 8'h00);
    end
    else if (run_q)
    begin
      if (cyc_q == 16'(UNIT_CYC - 1))
      begin
        cyc_q   <= '0;
        units_q <= units_q - 8'h01;
        if (units_q == 8'h01)
        begin
          run_q  <= 1'b0;
          o_done <= 1'b1;
        end
      end
      else
        cyc_q <= cyc_q + 16'h0001;
    end
  end
endmodule : synth_settle_timer

// file: radio_rf_config_regs.sv
// rf configuration register set, device end of the register link
`timescale 1ns/1ps
module radio_rf_config_regs #(
  parameter logic [31:0] FACTORY_ID = 32'h0000_0000 // arbitrary value
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  rf_cfg_link_if.device    lk,
  input  wire logic        i_rx_enter,
  input  wire logic [4:0]  i_rx_level,
  input  wire logic        i_synth_manual,
  input  wire logic        i_pll_lock_used,
  input  wire logic        i_synth_start,
  output logic             o_use_counters,
  output logic [6:0]       o_channel,
  output logic [11:0]      o_freq_mhz,
  output logic [2:0]       o_tx_gain_code,
  output logic [5:0]       o_crystal_trim,
  output logic             o_buffered_clock_pin_en,
  output logic [1:0]       o_vco_slope,
  output logic             o_gain_hold_max,
  output logic             o_carrier_override,
  output logic [7:0]       o_clock_override,
  output logic [7:0]       o_clock_enable,
  output logic [7:0]       o_synth_lock_delay,
  output logic             o_synth_settled
);
  logic       ack_q;
  logic [7:0] rdata_q;
  logic       gain_wr_en_q;
  logic       id_read_en_q;
  logic       clkout_off_q;
  logic [4:0] level_q;
  logic       level_ok_q;
  logic       rx_prev_q;
  logic       synth_prev_q;
  logic       wr;
  logic       rd;
  logic       timer_start;

  assign wr = lk.req && lk.we && !ack_q;
  assign rd = lk.req && !lk.we && !ack_q;
  assign timer_start = i_synth_start && !synth_prev_q && !i_synth_manual
                       && !i_pll_lock_used;

  assign lk.ack   = ack_q;
  assign lk.rdata = rdata_q;

  // one answer per request; host holds req until ack
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      ack_q <= 1'b0;
    else
      ack_q <= lk.req && !ack_q;
  end

  // writable registers; only defined fields are kept
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      gain_wr_en_q       <= 1'b0;
      id_read_en_q       <= 1'b0;
      o_use_counters     <= 1'b0;
      o_channel          <= '0;
      o_tx_gain_code     <= '0;
      o_crystal_trim     <= '0;
      clkout_off_q       <= 1'b0;
      o_vco_slope        <= '0;
      o_gain_hold_max    <= 1'b0;
      o_carrier_override <= 1'b0;
      o_clock_override   <= rf_cfg_pkg::RST_ZERO;
      o_clock_enable     <= rf_cfg_pkg::RST_ZERO;
      o_synth_lock_delay <= rf_cfg_pkg::RST_LOCK_DELAY;
    end
    else if (wr)
    begin
      unique case (lk.addr)
        rf_cfg_pkg::OFF_CTL_ANALOG:
        begin
          gain_wr_en_q <= lk.wdata[rf_cfg_pkg::BIT_GAIN_ENABLE];
          id_read_en_q <= lk.wdata[rf_cfg_pkg::BIT_ID_READ];
        end
        rf_cfg_pkg::OFF_CHANNEL:
        begin
          o_use_counters <= lk.wdata[rf_cfg_pkg::BIT_USE_COUNTERS];
          o_channel      <= lk.wdata[6:0];
        end
        rf_cfg_pkg::OFF_TX_POWER: o_tx_gain_code <= lk.wdata[2:0];
        rf_cfg_pkg::OFF_CRYSTAL:
        begin
          clkout_off_q   <= lk.wdata[rf_cfg_pkg::BIT_CLKOUT_OFF];
          o_crystal_trim <= lk.wdata[5:0];
        end
        rf_cfg_pkg::OFF_VCO_SLOPE: o_vco_slope <= lk.wdata[7:6];
        rf_cfg_pkg::OFF_GAIN_LOCK:
          if (gain_wr_en_q)
            o_gain_hold_max <= lk.wdata[rf_cfg_pkg::BIT_GAIN_HOLD];
        rf_cfg_pkg::OFF_CARRIER:
          if (gain_wr_en_q)
            o_carrier_override <= lk.wdata[rf_cfg_pkg::BIT_CARRIER_OVR];
        rf_cfg_pkg::OFF_CLK_OVERRIDE: o_clock_override <= lk.wdata;
        rf_cfg_pkg::OFF_CLK_ENABLE:   o_clock_enable   <= lk.wdata;
        rf_cfg_pkg::OFF_LOCK_DELAY:   o_synth_lock_delay <= lk.wdata;
        default: ;
      endcase
    end
  end

  // frequency follows the stored channel one cycle later
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_freq_mhz              <= '0;
      o_buffered_clock_pin_en <= 1'b1;
    end
    else
    begin
      o_freq_mhz <= rf_cfg_pkg::CHAN_BASE_MHZ + {5'h00, o_channel};
      o_buffered_clock_pin_en <= !clkout_off_q;
    end
  end

  // one sample per receive entry, kept until the next entry
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rx_prev_q    <= 1'b0;
      synth_prev_q <= 1'b0;
      level_q      <= '0;
      level_ok_q   <= 1'b0;
    end
    else
    begin
      rx_prev_q    <= i_rx_enter;
      synth_prev_q <= i_synth_start;
      if (i_rx_enter && !rx_prev_q)
      begin
        level_q    <= i_rx_level;
        level_ok_q <= 1'b1;
      end
    end
  end

  // read answers; vco slope reads as zero
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rdata_q <= '0;
    else if (rd)
    begin
      unique case (lk.addr)
        rf_cfg_pkg::OFF_CTL_ANALOG:
          rdata_q <= {1'b0, gain_wr_en_q, id_read_en_q, 5'h00};
        rf_cfg_pkg::OFF_CHANNEL:  rdata_q <= {o_use_counters, o_channel};
        rf_cfg_pkg::OFF_STRENGTH:
          rdata_q <= {2'b00, level_ok_q, level_q};
        rf_cfg_pkg::OFF_TX_POWER: rdata_q <= {5'h00, o_tx_gain_code};
        rf_cfg_pkg::OFF_CRYSTAL:
          rdata_q <= {1'b0, clkout_off_q, o_crystal_trim};
        rf_cfg_pkg::OFF_GAIN_LOCK:    rdata_q <= {o_gain_hold_max, 7'h00};
        rf_cfg_pkg::OFF_CARRIER:      rdata_q <= {o_carrier_override, 7'h00};
        rf_cfg_pkg::OFF_CLK_OVERRIDE: rdata_q <= o_clock_override;
        rf_cfg_pkg::OFF_CLK_ENABLE:   rdata_q <= o_clock_enable;
        rf_cfg_pkg::OFF_LOCK_DELAY:   rdata_q <= o_synth_lock_delay;
        default:
          // id bytes, gated to zero while reading is not enabled
          if (lk.addr >= rf_cfg_pkg::OFF_ID_BYTE0 && id_read_en_q)
            rdata_q <= FACTORY_ID[8*(lk.addr[1:0]) +: 8];
          else
            rdata_q <= '0;
      endcase
    end
  end

  synth_settle_timer #(
    .UNIT_CYC (rf_cfg_pkg::LOCK_UNIT_CYC)
  ) u_settle (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_start (timer_start),
    .i_units (o_synth_lock_delay),
    .o_done  (o_synth_settled)
  );
endmodule : radio_rf_config_regs

// file: radio_rf_config_regs_checker.sv
// link protocol and readback checks for the rf register set
`timescale 1ns/1ps
module radio_rf_config_regs_checker (
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic       req,
  input wire logic       we,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata
);
  logic [1:0] ana_q;
  logic       gain_q;
  logic       lock_wr_q;
  logic [7:0] chan_q;
  logic       wr_ok;
  logic       rd_ok;

  assign wr_ok = ack && we;
  assign rd_ok = ack && !we;

  // shadows follow completed writes; gain only while the gate bit is set
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
    begin
      ana_q     <= 2'b00;
      gain_q    <= 1'b0;
      lock_wr_q <= 1'b0;
      chan_q    <= 8'h00;
    end
    else if (wr_ok)
    begin
      if (addr == rf_cfg_pkg::OFF_CTL_ANALOG) ana_q <= wdata[6:5];
      if (addr == rf_cfg_pkg::OFF_GAIN_LOCK && ana_q[1]) gain_q <= wdata[7];
      if (addr == rf_cfg_pkg::OFF_LOCK_DELAY) lock_wr_q <= 1'b1;
      if (addr == rf_cfg_pkg::OFF_CHANNEL) chan_q <= wdata;
    end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_take;
    req && !ack;
  endsequence

  sequence s_answer;
    ack ##1 (!ack && !req);
  endsequence

  a_take_answer: assert property (s_take |=> s_answer)
    else $error("link request not answered by a single ack");
  a_req_hold: assert property (s_take |=>
    $stable(addr) && $stable(we) && $stable(wdata))
    else $error("link request changed before ack");
  a_ack_cause: assert property (ack |-> $past(req) && !$past(ack))
    else $error("ack without a pending request");
  a_id_gated: assert property (
    rd_ok && addr >= rf_cfg_pkg::OFF_ID_BYTE0 && !ana_q[0] |-> rdata == 8'h00)
    else $error("id byte readable while read enable is clear");
  a_strength_rsvd: assert property (
    rd_ok && addr == rf_cfg_pkg::OFF_STRENGTH |-> rdata[7:6] == 2'b00)
    else $error("strength reserved bits not zero");
  a_lock_default: assert property (
    rd_ok && addr == rf_cfg_pkg::OFF_LOCK_DELAY && !lock_wr_q
    |-> rdata == rf_cfg_pkg::RST_LOCK_DELAY)
    else $error("lock delay reset value wrong");
  a_chan_readback: assert property (
    rd_ok && addr == rf_cfg_pkg::OFF_CHANNEL |-> rdata == chan_q)
    else $error("channel readback differs from last write");
  a_gain_gated: assert property (
    rd_ok && addr == rf_cfg_pkg::OFF_GAIN_LOCK |-> rdata == {gain_q, 7'h00})
    else $error("gain lock write taken while gate bit clear");
endmodule : radio_rf_config_regs_checker

// file: radio_rf_config_regs_tb_top.sv
// self-checking bench: controller and rf register set joined by the link
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("[ERR] %0t got %h exp %h", $time, (g), (e)); \
    end \
  end
module radio_rf_config_regs_tb_top;
  localparam logic [31:0] FID = 32'h5ac3_17e9; // arbitrary value
  localparam int          U   = rf_cfg_pkg::LOCK_UNIT_CYC;
  logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, init_done;
  logic        rx_enter, synth_go, use_cnt, clk_pin_en, hold_max;
  logic        car_ovr, settled, synth_man, pll_used;
  logic [1:0]  bresp, rresp, slope, r;
  logic [2:0]  gain_code;
  logic [3:0]  awaddr, araddr;
  logic [4:0]  rx_level;
  logic [5:0]  trim;
  logic [6:0]  chan;
  logic [7:0]  clk_ovr, clk_en, lock_dly, q, v;
  logic [11:0] freq;
  logic [31:0] wdat, rdat, s;
  int          n, error_cnt, tests_run;

  rf_cfg_link_if lk_if ();

  rf_cfg_host_ctrl i_rf_cfg_host_ctrl (
    .i_clk(clk), .i_nrst(nrst), .lk(lk_if), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdat), .i_s_axi_wstrb(4'hf),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .o_init_done(init_done));

  radio_rf_config_regs #(.FACTORY_ID(FID)) i_radio_rf_config_regs (
    .i_clk(clk), .i_nrst(nrst), .lk(lk_if), .i_rx_enter(rx_enter),
    .i_rx_level(rx_level), .i_synth_manual(synth_man),
    .i_pll_lock_used(pll_used), .i_synth_start(synth_go),
    .o_use_counters(use_cnt), .o_channel(chan), .o_freq_mhz(freq),
    .o_tx_gain_code(gain_code), .o_crystal_trim(trim),
    .o_buffered_clock_pin_en(clk_pin_en), .o_vco_slope(slope),
    .o_gain_hold_max(hold_max), .o_carrier_override(car_ovr),
    .o_clock_override(clk_ovr), .o_clock_enable(clk_en),
    .o_synth_lock_delay(lock_dly), .o_synth_settled(settled));

  radio_rf_config_regs_checker i_radio_rf_config_regs_checker (
    .i_clk(clk), .i_nrst(nrst), .req(lk_if.req), .we(lk_if.we),
    .addr(lk_if.addr), .wdata(lk_if.wdata), .ack(lk_if.ack),
    .rdata(lk_if.rdata));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  function automatic logic [11:0] exp_freq(input logic [6:0] c);
    return 12'h961 + 12'(c);
  endfunction : exp_freq

  // leading edge keeps a released valid or ready from being re-driven
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        output logic [1:0] rs);
    int k;
    k = 0;
    @(posedge clk);
    awaddr <= a;
    wdat <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && ++k < 99);
    if (k >= 99) `CHK(bvalid, 1'b1)
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] rs);
    int k;
    k = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && ++k < 99);
    if (k >= 99) `CHK(rvalid, 1'b1)
    d = rdat;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // one link transfer through the command register, then poll for idle
  task automatic lk_op(input logic w, input logic [5:0] a,
                       input logic [7:0] d, output logic [7:0] rd);
    logic [31:0] st;
    logic [1:0]  rs;
    int          k;
    k = 0;
    axi_wr(rf_cfg_pkg::AXI_OFF_CMD, {16'h0000, w, 1'b0, a, d}, rs);
    `CHK(rs, rf_cfg_pkg::RESP_OKAY)
    do
      axi_rd(rf_cfg_pkg::AXI_OFF_STATUS, st, rs);
    while (st[rf_cfg_pkg::STAT_BIT_BUSY] !== 1'b0 && ++k < 20);
    if (k >= 20) `CHK(st[rf_cfg_pkg::STAT_BIT_BUSY], 1'b0)
    rd = st[7:0];
  endtask : lk_op

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // expected run is under 2500 cycles
  initial
  begin
    repeat (10000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    {awaddr, awvalid, wdat, wvalid, bready} = '0;
    {araddr, arvalid, rready, rx_enter, rx_level, synth_go} = '0;
    {synth_man, pll_used} = '0;
    nrst = 1'b0;
    tests_run = 0;
    error_cnt = 0;
    void'($urandom(32'hd11a));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    `CHK(clk_pin_en, 1'b1)
    axi_wr(rf_cfg_pkg::AXI_OFF_CMD, 32'h0000_8000, r);
    `CHK(r, rf_cfg_pkg::RESP_SLVERR)
    n = 0;
    while (init_done !== 1'b1 && n++ < 300) @(posedge clk);
    `CHK(init_done, 1'b1)
    `CHK(gain_code, 3'h7)
    `CHK(slope, 2'b11)
    `CHK(hold_max, 1'b1)
    `CHK(clk_ovr, 8'h41)
    `CHK(clk_en, 8'h41)
    `CHK(clk_pin_en, 1'b0)
    `CHK(lock_dly, 8'h64)
    lk_op(1'b0, 6'h22, 8'h00, q);
    `CHK(q[5], 1'b0)
    lk_op(1'b0, 6'h38, 8'h00, q);
    `CHK(q, 8'h64)
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 8'h01 : (i == 1) ? 8'hcf : 8'($urandom);
      lk_op(1'b1, 6'h21, v, q);
      `CHK(chan, v[6:0])
      `CHK(use_cnt, v[7])
      `CHK(freq, exp_freq(v[6:0]))
      lk_op(1'b0, 6'h21, 8'h00, q);
      `CHK(q, v)
    end
    for (int k = 0; k < 8; k++)
    begin
      lk_op(1'b1, 6'h23, 8'(k), q);
      `CHK(gain_code, 3'(k))
    end
    // code 01 is reserved, so only its write is exercised
    for (int k = 3; k >= 0; k--)
    begin
      lk_op(1'b1, 6'h26, {2'(k), 6'h00}, q);
      if (k != 1) `CHK(slope, 2'(k))
    end
    v = {2'b00, 6'($urandom)};
    lk_op(1'b1, 6'h24, v, q);
    `CHK(trim, v[5:0])
    `CHK(clk_pin_en, 1'b1)
    lk_op(1'b1, 6'h24, v | 8'h40, q);
    `CHK(clk_pin_en, 1'b0)
    v = {3'b001, 5'($urandom)};
    rx_level <= v[4:0];
    rx_enter <= 1'b1;
    repeat (3) @(posedge clk);
    rx_enter <= 1'b0;
    rx_level <= ~v[4:0];
    lk_op(1'b0, 6'h22, 8'h00, q);
    `CHK(q, v)
    lk_op(1'b1, 6'h22, 8'h3f, q);
    lk_op(1'b0, 6'h22, 8'h00, q);
    `CHK(q, v)
    // a fresh receive entry takes the level now on the pins
    rx_enter <= 1'b1;
    repeat (3) @(posedge clk);
    rx_enter <= 1'b0;
    lk_op(1'b0, 6'h22, 8'h00, q);
    `CHK(q, {3'b001, ~v[4:0]})
    lk_op(1'b1, 6'h20, 8'h00, q);
    lk_op(1'b1, 6'h2f, 8'h80, q);
    `CHK(car_ovr, 1'b0)
    lk_op(1'b1, 6'h2e, 8'h00, q);
    `CHK(hold_max, 1'b1)
    lk_op(1'b0, 6'h2e, 8'h00, q);
    lk_op(1'b1, 6'h20, 8'h40, q);
    lk_op(1'b1, 6'h2f, 8'h80, q);
    `CHK(car_ovr, 1'b1)
    lk_op(1'b1, 6'h2e, 8'h00, q);
    `CHK(hold_max, 1'b0)
    lk_op(1'b0, 6'h3d, 8'h00, q);
    `CHK(q, 8'h00)
    lk_op(1'b1, 6'h20, 8'h60, q);
    for (int i = 0; i < 4; i++)
    begin
      lk_op(1'b0, 6'h3c + 6'(i), 8'h00, q);
      `CHK(q, FID[8*i +: 8])
    end
    lk_op(1'b1, 6'h20, 8'h40, q);
    lk_op(1'b1, 6'h38, 8'h02, q);
    `CHK(lock_dly, 8'h02)
    // pll lock in use, then manual synth: no settle wait may run
    for (int m = 1; m < 3; m++)
    begin
      {synth_man, pll_used} <= 2'(m);
      synth_go <= 1'b1;
      repeat (2 * U + 8) @(posedge clk);
      `CHK(settled, 1'b0)
      synth_go <= 1'b0;
      @(posedge clk);
    end
    {synth_man, pll_used} <= 2'b00;
    synth_go <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (settled !== 1'b1 && n < 600);
    synth_go <= 1'b0;
    `CHK(n >= 2 * U && n <= 2 * U + 4, 1'b1)
    axi_wr(4'h8, $urandom, r);
    `CHK(r, rf_cfg_pkg::RESP_SLVERR)
    axi_rd(4'hc, s, r);
    `CHK(r, rf_cfg_pkg::RESP_SLVERR)
    `CHK(s, 32'h0000_0000)
    axi_rd(rf_cfg_pkg::AXI_OFF_STATUS, s, r);
    `CHK(s[rf_cfg_pkg::STAT_BIT_INIT], 1'b1)
    `CHK(s[rf_cfg_pkg::STAT_BIT_BUSY], 1'b0)
    report_and_stop();
  end
endmodule : radio_rf_config_regs_tb_top
